// *** pkg/discard_stats_map.vh ***
// register map and constants for the discarded-frame statistics block
`ifndef DISCARD_STATS_MAP_VH
`define DISCARD_STATS_MAP_VH
// register word indices; the byte address is four times the index
`define IDX_LOW_CMD_DISCARD 12'h266
`define IDX_LOW_RSP_DISCARD 12'h268
`define IDX_HIGH_CMD_DISCARD 12'h269
`define IDX_HIGH_RSP_DISCARD 12'h267
`define IDX_HOST_RSP_DISCARD 12'h26A
`define IDX_HOST_CMD_DISCARD 12'h265
`define IDX_IRQ_STATUS 12'h270
`define IDX_IRQ_MASK 12'h271
// counter reset value and ceiling
`define CNT_RESET 8'h00
`define CNT_MAX 8'hFF
// interrupt status bit positions
`define IRQ_LOW_SAT 0
`define IRQ_HIGH_SAT 1
`define IRQ_HOST_SAT 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0
`endif

// *** design/discard_stats.v ***
// discarded-frame statistics counters with snapshot-on-read over ahb-lite
`include "discard_stats_map.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - count low-side discarded response frames in 8 bits, reset zero
// - reading low-side command-discard register snapshots and clears low-side group
// - count high-side discarded command frames in 8 bits, reset zero
// - reading high-side response-discard register snapshots and clears high-side group
// - count host-port discarded response frames in 8 bits, reset zero
// - reading host-port command-discard register snapshots and clears host group
// - frames discarded for integrity error are never counted
// - low-side command-discard register sits at word index 0x266, byte offset 0x998
module discard_stats (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // discard events, one-cycle pulses
    input wire lowCmdDiscard,
    input wire lowRspDiscard,
    input wire highCmdDiscard,
    input wire highRspDiscard,
    input wire hostCmdDiscard,
    input wire hostRspDiscard,
    input wire frameIntegrityError,
    // interrupt
    output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// live counters and snapshot copies: 0 low, 1 high, 2 host
reg [7:0] liveCmd_r [0:2];
reg [7:0] liveRsp_r [0:2];
reg [7:0] snapCmd_r [0:2];
reg [7:0] snapRsp_r [0:2];
reg [2:0] irqStatus_r;
reg [2:0] irqMask_r;
reg [11:0] dataAddr_r;
reg dataRead_r;
reg dataWrite_r;
wire [2:0] cmdEv;
wire [2:0] rspEv;
wire [2:0] snapTrig;
wire [2:0] satEv;
wire addrTaken;
wire [11:0] rdAddr;
reg [31:0] rdData;
integer i;

// address phase acceptance
assign addrTaken = hsel && hready && htrans[1];
assign rdAddr = haddr[13:2]; // word index, byte address is index times four

assign cmdEv = {hostCmdDiscard, highCmdDiscard, lowCmdDiscard} & {3{~frameIntegrityError}};
assign rspEv = {hostRspDiscard, highRspDiscard, lowRspDiscard} & {3{~frameIntegrityError}};

assign snapTrig[0] = addrTaken && !hwrite && rdAddr == `IDX_LOW_CMD_DISCARD;
assign snapTrig[1] = addrTaken && !hwrite && rdAddr == `IDX_HIGH_RSP_DISCARD;
assign snapTrig[2] = addrTaken && !hwrite && rdAddr == `IDX_HOST_CMD_DISCARD;

// saturation events per group
assign satEv[0] = (cmdEv[0] && liveCmd_r[0] == `CNT_MAX) || (rspEv[0] && liveRsp_r[0] == `CNT_MAX);
assign satEv[1] = (cmdEv[1] && liveCmd_r[1] == `CNT_MAX) || (rspEv[1] && liveRsp_r[1] == `CNT_MAX);
assign satEv[2] = (cmdEv[2] && liveCmd_r[2] == `CNT_MAX) || (rspEv[2] && liveRsp_r[2] == `CNT_MAX);

////////////////////////////////////////////////////////////////////////////////
// counters, snapshot and clear
always @(posedge sys_clk) begin
    for (i = 0; i < 3; i = i + 1) begin
        if (sys_rst) begin
            liveCmd_r[i] <= `CNT_RESET;
            liveRsp_r[i] <= `CNT_RESET;
            snapCmd_r[i] <= `CNT_RESET;
            snapRsp_r[i] <= `CNT_RESET;
        end else if (snapTrig[i]) begin
            snapCmd_r[i] <= (cmdEv[i] && liveCmd_r[i] != `CNT_MAX) ? liveCmd_r[i] + 8'h01 : liveCmd_r[i];
            snapRsp_r[i] <= (rspEv[i] && liveRsp_r[i] != `CNT_MAX) ? liveRsp_r[i] + 8'h01 : liveRsp_r[i];
            liveCmd_r[i] <= `CNT_RESET;
            liveRsp_r[i] <= `CNT_RESET;
        end else begin
            if (cmdEv[i] && liveCmd_r[i] != `CNT_MAX)
                liveCmd_r[i] <= liveCmd_r[i] + 8'h01;
            if (rspEv[i] && liveRsp_r[i] != `CNT_MAX)
                liveRsp_r[i] <= liveRsp_r[i] + 8'h01;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// data phase bookkeeping
always @(posedge sys_clk) begin
    if (sys_rst) begin
        dataAddr_r <= 12'h000;
        dataRead_r <= 1'b0;
        dataWrite_r <= 1'b0;
    end else if (hready) begin
        dataAddr_r <= rdAddr;
        dataRead_r <= addrTaken && !hwrite;
        dataWrite_r <= addrTaken && hwrite;
    end
end

// read mux, data registered at address phase (snapshot is taken same edge)
always @* begin
    case (rdAddr)
        `IDX_LOW_CMD_DISCARD: rdData = {24'h00_0000, (cmdEv[0] && liveCmd_r[0] != `CNT_MAX) ?
            liveCmd_r[0] + 8'h01 : liveCmd_r[0]};
        `IDX_LOW_RSP_DISCARD: rdData = {24'h00_0000, snapRsp_r[0]};
        `IDX_HIGH_CMD_DISCARD: rdData = {24'h00_0000, snapCmd_r[1]};
        `IDX_HIGH_RSP_DISCARD: rdData = {24'h00_0000, (rspEv[1] && liveRsp_r[1] != `CNT_MAX) ?
            liveRsp_r[1] + 8'h01 : liveRsp_r[1]};
        `IDX_HOST_RSP_DISCARD: rdData = {24'h00_0000, snapRsp_r[2]};
        `IDX_HOST_CMD_DISCARD: rdData = {24'h00_0000, (cmdEv[2] && liveCmd_r[2] != `CNT_MAX) ?
            liveCmd_r[2] + 8'h01 : liveCmd_r[2]};
        `IDX_IRQ_STATUS: rdData = {29'h0000_0000, irqStatus_r};
        `IDX_IRQ_MASK: rdData = {29'h0000_0000, irqMask_r};
        default: rdData = 32'h0000_0000;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// bus outputs
always @(posedge sys_clk) begin
    if (sys_rst) begin
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (addrTaken && !hwrite)
            hrdata <= rdData;
        else if (hready)
            hrdata <= 32'h0000_0000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt status, mask and output; set wins over clear
always @(posedge sys_clk) begin
    if (sys_rst) begin
        irqStatus_r <= `IRQ_RESET;
        irqMask_r <= `IRQ_RESET;
        irq <= 1'b0;
    end else begin
        if (dataWrite_r && dataAddr_r == `IDX_IRQ_STATUS)
            irqStatus_r <= (irqStatus_r & ~hwdata[2:0]) | satEv;
        else
            irqStatus_r <= irqStatus_r | satEv;
        if (dataWrite_r && dataAddr_r == `IDX_IRQ_MASK)
            irqMask_r <= hwdata[2:0];
        irq <= |(irqStatus_r & irqMask_r);
    end
end

endmodule // discard_stats
`default_nettype wire

// *** dv/discard_stats_checker.sv ***
// concurrent checks on the discarded-frame statistics block
`default_nettype none
module discard_stats_checker (
    // clock and reset
    input wire logic sys_clk, sys_rst,
    // bus
    input wire logic hsel, hwrite, hreadyout, hresp,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr, hrdata,
    // events
    input wire logic lowCmdDiscard, highRspDiscard, hostCmdDiscard, frameIntegrityError
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // read request at one word index
    sequence rdAt(a);
        hsel && htrans[1] && !hwrite && haddr[13:2] == a;
    endsequence
    // two trigger reads with no counted event between
    property cleared(a, ev);
        rdAt(a) ##1 !(ev && !frameIntegrityError) ##1 (rdAt(a) && !(ev && !frameIntegrityError))
            |=> hrdata == 32'h0;
    endproperty
    a_low_clear: assert property (cleared(12'h266, lowCmdDiscard))
        else $error("low group not cleared");
    a_high_clear: assert property (cleared(12'h267, highRspDiscard))
        else $error("high group not cleared");
    a_host_clear: assert property (cleared(12'h265, hostCmdDiscard))
        else $error("host group not cleared");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_ready_high: assert property (hreadyout)
        else $error("wait state inserted");
    a_idle_zero: assert property (!(hsel && htrans[1]) |=> hrdata == 32'h0)
        else $error("read data not dropped");
    a_unmapped_zero: assert property (rdAt(12'h100) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // discard_stats_checker
`default_nettype wire

// *** dv/frame_source.sv ***
// far-side model issuing discarded-frame pulses
`default_nettype none
module frame_source (
    // clock
    input wire logic sys_clk,
    // discard pulses and integrity flag
    output logic [5:0] discard,
    output logic frameIntegrityError
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        discard = 6'h00;
        frameIntegrityError = 1'b0;
    end
    task automatic send(input int port, input int n, input logic bad);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            discard <= 6'(1 << port);
            frameIntegrityError <= bad;
            @(posedge sys_clk);
            discard <= 6'h00;
            frameIntegrityError <= 1'b0;
        end
    endtask
endmodule // frame_source
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the discarded-frame statistics block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irq, frameIntegrityError;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [5:0] discard;
    logic [11:0] trig[3] = '{12'h266, 12'h267, 12'h265};
    logic [11:0] oth[3] = '{12'h268, 12'h269, 12'h26A};
    int tp[3] = '{0, 3, 4};
    int op[3] = '{1, 2, 5};
    int mismatches, tests_run;
    discard_stats uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lowCmdDiscard(discard[0]), .lowRspDiscard(discard[1]),
        .highCmdDiscard(discard[2]), .highRspDiscard(discard[3]), .hostCmdDiscard(discard[4]),
        .hostRspDiscard(discard[5]), .frameIntegrityError(frameIntegrityError), .irq(irq));
    frame_source far (.sys_clk(sys_clk), .discard(discard), .frameIntegrityError(frameIntegrityError));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // one single transfer, entered just after an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {18'h0, a, 2'b00}; hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, v);
        check($sformatf("reg %h", a), exp, v);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        wrap_up();
    end
    initial begin
        mismatches = 0; tests_run = 0; sys_rst = 1'b1; hsel = 1'b0; htrans = 2'h0;
        haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int g = 0; g < 3; g++) rc(oth[g], 32'h0);
        for (int g = 0; g < 3; g++) begin
            far.send(op[g], 3, 1'b0);
            far.send(op[g], 2, 1'b1);
            far.send(tp[g], g + 1, 1'b0);
            rc(trig[g], g + 1);
            rc(oth[g], 32'h3);
            rc(trig[g], 32'h0);
            rc(trig[g], 32'h0);
            rc(oth[g], 32'h0);
            $display("group %0d done", g);
        end
        // saturation, masked then unmasked interrupt
        far.send(1, 257, 1'b0);
        check("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, 12'h271, 32'h1, v);
        repeat (2) @(posedge sys_clk);
        check("irq", 32'h1, {31'h0, irq});
        rc(12'h270, 32'h1);
        xfer(1'b1, 12'h270, 32'h1, v);
        repeat (2) @(posedge sys_clk);
        check("irq", 32'h0, {31'h0, irq});
        rc(12'h266, 32'h0);
        xfer(1'b1, 12'h268, 32'h55, v);
        rc(12'h268, 32'hFF);
        rc(12'h100, 32'h0);
        $display("saturation and bus done");
        wrap_up();
    end
endmodule // tb
bind discard_stats discard_stats_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
    .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans), .haddr(haddr), .hrdata(hrdata),
    .lowCmdDiscard(lowCmdDiscard), .highRspDiscard(highRspDiscard), .hostCmdDiscard(hostCmdDiscard),
    .frameIntegrityError(frameIntegrityError));
`default_nettype wire
